// ---- src/bsim_pkg.sv ----
// package: constants and types of the boundary-scan controller, instruction and data registers
package bsim_pkg;
    localparam int BSIM_IR_W   = 10;
    localparam int BSIM_ID_W   = 32;
    localparam int BSIM_PINS   = 4;
    localparam int BSIM_CELL_W = 3;

    // instruction codes, all but bypass fixed by this implementation
    localparam logic [BSIM_IR_W-1:0] BSIM_IR_EXTEST = 10'h000;
    localparam logic [BSIM_IR_W-1:0] BSIM_IR_SAMPLE = 10'h005;
    localparam logic [BSIM_IR_W-1:0] BSIM_IR_IDENT  = 10'h006;
    localparam logic [BSIM_IR_W-1:0] BSIM_IR_USER   = 10'h007;
    localparam logic [BSIM_IR_W-1:0] BSIM_IR_CLAMP  = 10'h00A;
    localparam logic [BSIM_IR_W-1:0] BSIM_IR_BYPASS = 10'h3FF;
    localparam logic [BSIM_IR_W-1:0] BSIM_IR_CAPT   = 10'h001;

    // arbitrary identification value, bit 0 set as the scan standard asks
    localparam logic [BSIM_ID_W-1:0] BSIM_IDCODE_DEF  = 32'h0A5A_5001;
    localparam logic [BSIM_ID_W-1:0] BSIM_USERSIG_DEF = 32'hFFFF_FFFF;

    typedef enum logic [15:0] {
        TapReset = 16'h0001,
        TapIdle  = 16'h0002,
        TapSelDr = 16'h0004,
        TapCapDr = 16'h0008,
        TapShDr  = 16'h0010,
        TapEx1Dr = 16'h0020,
        TapPsDr  = 16'h0040,
        TapEx2Dr = 16'h0080,
        TapUpdDr = 16'h0100,
        TapSelIr = 16'h0200,
        TapCapIr = 16'h0400,
        TapShIr  = 16'h0800,
        TapEx1Ir = 16'h1000,
        TapPsIr  = 16'h2000,
        TapEx2Ir = 16'h4000,
        TapUpdIr = 16'h8000
    } bsim_tap_t;

    typedef enum logic [2:0] {
        DrBound  = 3'h1,
        DrBypass = 3'h2,
        DrIdent  = 3'h4
    } bsim_dr_t;

    // one boundary cell group per pin; inV is the bit nearest tdo
    typedef struct packed {
        logic outV;
        logic oeN;
        logic inV;
    } bsim_cell_t;

    typedef struct packed {
        logic extest;
        logic clamp;
    } bsim_mode_t;

    // data register placed between tdi and tdo by an instruction
    function automatic bsim_dr_t bsimDrSel(input logic [BSIM_IR_W-1:0] ir);
        bsim_dr_t sel;
        sel = DrBypass;
        if (ir == BSIM_IR_SAMPLE || ir == BSIM_IR_EXTEST) begin
            sel = DrBound;
        end else if (ir == BSIM_IR_IDENT || ir == BSIM_IR_USER) begin
            sel = DrIdent;
        end
        return sel;
    endfunction
endpackage

// ---- src/bsim_sync.sv ----
// two-flop level synchroniser, one per bit
`timescale 1ns/1ns
module bsim_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input  wire logic             clk,
    input  wire logic             rstN,
    // level from the foreign domain and its synchronised copy
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ---- src/bsim_top.sv ----
// boundary-scan controller, data registers and pin multiplexers
`timescale 1ns/1ns
module bsim_top
    import bsim_pkg::*;
#(
    parameter int                     NUM_PINS = bsim_pkg::BSIM_PINS,
    parameter logic [BSIM_ID_W-1:0]   ID_CODE  = bsim_pkg::BSIM_IDCODE_DEF,
    parameter logic [BSIM_ID_W-1:0]   SIG_DEF  = bsim_pkg::BSIM_USERSIG_DEF
) (
    // core clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    // test port
    input  wire logic                 tck,
    input  wire logic                 trstN,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    output logic                      tdo,
    output logic                      tdoOe,
    // device pins
    input  wire logic [NUM_PINS-1:0]  padIn,
    output logic      [NUM_PINS-1:0]  padOut,
    output logic      [NUM_PINS-1:0]  padOe,
    // core side of the pins
    input  wire logic [NUM_PINS-1:0]  coreOutputValue,
    input  wire logic [NUM_PINS-1:0]  coreOutputEnableN,
    output logic      [NUM_PINS-1:0]  coreInputSubstitute,
    // configuration state
    input  wire logic                 cfgDone,
    input  wire logic [BSIM_ID_W-1:0] userSignature,
    input  wire logic [NUM_PINS-1:0]  keeperEn
);
    import bsim_pkg::*;

    localparam int CHAIN_W = NUM_PINS * BSIM_CELL_W;
    localparam int LIVE_W  = CHAIN_W + 1;

    if (NUM_PINS < 1) begin : gChk
        $error("bsim_top needs at least one pin");
    end

    logic linkRstN;
    assign linkRstN = arst_n & trstN;

    // ---------------- link domain: inputs from the core side and pins ----
    logic [LIVE_W-1:0]          liveT;
    logic                       ackT;
    logic                       cfgDoneT;
    bsim_cell_t [NUM_PINS-1:0]  liveCell;

    bsim_sync #(.WIDTH(LIVE_W)) uLiveSync (
        .clk  (tck),
        .rstN (linkRstN),
        .d    ({cfgDone, coreOutputValue, coreOutputEnableN, padIn}),
        .q    (liveT)
    );

    assign cfgDoneT = liveT[LIVE_W-1];

    for (genvar i = 0; i < NUM_PINS; i++) begin : gLive
        assign liveCell[i].outV = liveT[2*NUM_PINS+i];
        assign liveCell[i].oeN  = liveT[NUM_PINS+i];
        assign liveCell[i].inV  = liveT[i];
    end

    // ---------------- controller state -------------------------------
    bsim_tap_t tapQ;
    bsim_tap_t tapD;

    always_comb begin
        case (tapQ)
            TapReset: tapD = tms ? TapReset : TapIdle;
            TapIdle:  tapD = tms ? TapSelDr : TapIdle;
            TapSelDr: tapD = tms ? TapSelIr : TapCapDr;
            TapCapDr: tapD = tms ? TapEx1Dr : TapShDr;
            TapShDr:  tapD = tms ? TapEx1Dr : TapShDr;
            TapEx1Dr: tapD = tms ? TapUpdDr : TapPsDr;
            TapPsDr:  tapD = tms ? TapEx2Dr : TapPsDr;
            TapEx2Dr: tapD = tms ? TapUpdDr : TapShDr;
            TapUpdDr: tapD = tms ? TapSelDr : TapIdle;
            TapSelIr: tapD = tms ? TapReset : TapCapIr;
            TapCapIr: tapD = tms ? TapEx1Ir : TapShIr;
            TapShIr:  tapD = tms ? TapEx1Ir : TapShIr;
            TapEx1Ir: tapD = tms ? TapUpdIr : TapPsIr;
            TapPsIr:  tapD = tms ? TapEx2Ir : TapPsIr;
            TapEx2Ir: tapD = tms ? TapUpdIr : TapShIr;
            TapUpdIr: tapD = tms ? TapSelDr : TapIdle;
            default:  tapD = TapReset;
        endcase
    end

    always_ff @(posedge tck or negedge linkRstN) begin
        if (!linkRstN) begin
            tapQ <= TapReset;
        end else begin
            tapQ <= tapD;
        end
    end

    // ---------------- instruction register ---------------------------
    logic [BSIM_IR_W-1:0] irShQ;
    logic [BSIM_IR_W-1:0] irShD;
    logic [BSIM_IR_W-1:0] irQ;
    logic [BSIM_IR_W-1:0] irD;

    always_comb begin
        irShD = irShQ;
        irD   = irQ;
        case (tapQ)
            TapCapIr: irShD = BSIM_IR_CAPT;
            TapShIr:  irShD = {tdi, irShQ[BSIM_IR_W-1:1]};
            TapUpdIr: irD   = irShQ;
            TapReset: irD   = BSIM_IR_IDENT;
            default:  irD   = irQ;
        endcase
    end

    always_ff @(posedge tck or negedge linkRstN) begin
        if (!linkRstN) begin
            irShQ <= BSIM_IR_CAPT;
            irQ   <= BSIM_IR_IDENT;
        end else begin
            irShQ <= irShD;
            irQ   <= irD;
        end
    end

    // ---------------- data registers ---------------------------------
    bsim_dr_t                  drSel;
    logic [CHAIN_W-1:0]        capQ;
    logic [CHAIN_W-1:0]        capD;
    bsim_cell_t [NUM_PINS-1:0] updQ;
    bsim_cell_t [NUM_PINS-1:0] updD;
    logic                      bypQ;
    logic                      bypD;
    logic [BSIM_ID_W-1:0]      idQ;
    logic [BSIM_ID_W-1:0]      idD;
    logic [BSIM_ID_W-1:0]      sigT;

    assign drSel = bsimDrSel(irQ);
    // signature is static once configuration reports done
    assign sigT  = cfgDoneT ? userSignature : SIG_DEF;

    always_comb begin
        capD = capQ;
        updD = updQ;
        bypD = bypQ;
        idD  = idQ;
        case (tapQ)
            TapCapDr: begin
                if (drSel == DrBound) begin
                    capD = liveCell;
                end
                bypD = 1'b0;
                if (irQ == BSIM_IR_USER) begin
                    idD = sigT;
                end else begin
                    idD = ID_CODE;
                end
            end
            TapShDr: begin
                if (drSel == DrBound) begin
                    capD = {tdi, capQ[CHAIN_W-1:1]};
                end
                bypD = tdi;
                if (drSel == DrIdent) begin
                    idD = {tdi, idQ[BSIM_ID_W-1:1]};
                end
            end
            TapUpdDr: begin
                if (drSel == DrBound) begin
                    updD = capQ;
                end
            end
            default: begin
                capD = capQ;
            end
        endcase
    end

    always_ff @(posedge tck or negedge linkRstN) begin
        if (!linkRstN) begin
            capQ <= '0;
            updQ <= '0;
            bypQ <= 1'b0;
            idQ  <= '0;
        end else begin
            capQ <= capD;
            updQ <= updD;
            bypQ <= bypD;
            idQ  <= idD;
        end
    end

    // ---------------- tdo on the falling edge ------------------------
    logic tdoD;
    logic shiftNow;

    assign shiftNow = (tapQ == TapShIr) || (tapQ == TapShDr);

    always_comb begin
        if (tapQ == TapShIr) begin
            tdoD = irShQ[0];
        end else begin
            case (drSel)
                DrBound:  tdoD = capQ[0];
                DrIdent:  tdoD = idQ[0];
                DrBypass: tdoD = bypQ;
                default:  tdoD = bypQ;
            endcase
        end
    end

    always_ff @(negedge tck or negedge linkRstN) begin
        if (!linkRstN) begin
            tdo   <= 1'b0;
            tdoOe <= 1'b0;
        end else begin
            tdo   <= tdoD;
            tdoOe <= shiftNow;
        end
    end

    // ---------------- hand-over of update cells to core side ---------
    bsim_mode_t                curMode;
    bsim_mode_t                xferModeQ;
    bsim_mode_t                xferModeD;
    bsim_cell_t [NUM_PINS-1:0] xferCellQ;
    bsim_cell_t [NUM_PINS-1:0] xferCellD;
    logic                      reqQ;
    logic                      reqD;
    logic                      dirtyQ;
    logic                      dirtyD;
    logic                      busy;
    logic                      change;

    assign curMode.extest = (irQ == BSIM_IR_EXTEST);
    assign curMode.clamp  = (irQ == BSIM_IR_CLAMP);
    assign busy   = reqQ ^ ackT;
    assign change = (tapQ == TapUpdDr) || (tapQ == TapUpdIr) ||
                    ((tapQ == TapReset) && (irQ != BSIM_IR_IDENT));

    always_comb begin
        xferModeD = xferModeQ;
        xferCellD = xferCellQ;
        reqD      = reqQ;
        dirtyD    = dirtyQ;
        // data words stay frozen until the core side acknowledges
        if (!busy && dirtyQ) begin
            xferModeD = curMode;
            xferCellD = updQ;
            reqD      = ~reqQ;
            dirtyD    = 1'b0;
        end
        if (change) begin
            dirtyD = 1'b1;
        end
    end

    always_ff @(posedge tck or negedge linkRstN) begin
        if (!linkRstN) begin
            xferModeQ <= '0;
            xferCellQ <= '0;
            reqQ      <= 1'b0;
            dirtyQ    <= 1'b1; // resend normal mode after reset
        end else begin
            xferModeQ <= xferModeD;
            xferCellQ <= xferCellD;
            reqQ      <= reqD;
            dirtyQ    <= dirtyD;
        end
    end

    // ---------------- core domain ------------------------------------
    logic                      reqC;
    logic                      seenQ;
    logic                      seenD;
    logic [NUM_PINS-1:0]       padInC;
    bsim_mode_t                modeCQ;
    bsim_mode_t                modeCD;
    bsim_cell_t [NUM_PINS-1:0] cellCQ;
    bsim_cell_t [NUM_PINS-1:0] cellCD;

    bsim_sync #(.WIDTH(1)) uReqSync (
        .clk  (core_clk),
        .rstN (arst_n),
        .d    (reqQ),
        .q    (reqC)
    );

    bsim_sync #(.WIDTH(1)) uAckSync (
        .clk  (tck),
        .rstN (linkRstN),
        .d    (seenQ),
        .q    (ackT)
    );

    bsim_sync #(.WIDTH(NUM_PINS)) uPadSync (
        .clk  (core_clk),
        .rstN (arst_n),
        .d    (padIn),
        .q    (padInC)
    );

    always_comb begin
        modeCD = modeCQ;
        cellCD = cellCQ;
        seenD  = seenQ;
        if (reqC != seenQ) begin
            modeCD = xferModeQ;
            cellCD = xferCellQ;
            seenD  = reqC;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            modeCQ <= '0;
            cellCQ <= '0;
            seenQ  <= 1'b0;
        end else begin
            modeCQ <= modeCD;
            cellCQ <= cellCD;
            seenQ  <= seenD;
        end
    end

    // pin multiplexers, registered
    logic [NUM_PINS-1:0] padOutD;
    logic [NUM_PINS-1:0] padOeD;
    logic [NUM_PINS-1:0] coreInD;
    logic                forced;

    assign forced = modeCQ.extest || modeCQ.clamp;

    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (forced) begin
                padOutD[i] = cellCQ[i].outV;
                padOeD[i]  = !cellCQ[i].oeN &&
                             !(modeCQ.clamp && cfgDone && keeperEn[i]);
            end else begin
                padOutD[i] = coreOutputValue[i];
                padOeD[i]  = !coreOutputEnableN[i];
            end
            if (modeCQ.extest) begin
                coreInD[i] = cellCQ[i].inV;
            end else begin
                coreInD[i] = padInC[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            padOut              <= '0;
            padOe               <= '0;
            coreInputSubstitute <= '0;
        end else begin
            padOut              <= padOutD;
            padOe               <= padOeD;
            coreInputSubstitute <= coreInD;
        end
    end
endmodule

// ---- verification/bsim_top_chk.sv ----
// port-level assertions for the boundary-scan block
`timescale 1ns/1ns
module bsim_top_chk #(
    parameter int NUM_PINS = 4
) (
    // clocks and resets
    input wire logic                core_clk,
    input wire logic                arst_n,
    input wire logic                tck,
    input wire logic                trstN,
    // test port
    input wire logic                tms,
    input wire logic                tdoOe,
    // pins and core side
    input wire logic [NUM_PINS-1:0] padIn,
    input wire logic [NUM_PINS-1:0] padOut,
    input wire logic [NUM_PINS-1:0] padOe,
    input wire logic [NUM_PINS-1:0] coreOutputValue,
    input wire logic [NUM_PINS-1:0] coreOutputEnableN,
    input wire logic [NUM_PINS-1:0] coreInputSubstitute
);
    logic tapRstN;
    logic armed_d;
    logic armed_q;
    assign tapRstN = arst_n & trstN;
    // set once a tck edge has passed since the last reset
    always_comb armed_d = 1'b1;
    always_ff @(posedge tck or negedge tapRstN) begin
        if (!tapRstN) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
        end
    end
    tdo_off_a: assert property (@(posedge tck)
        disable iff (!tapRstN) tms |=> !tdoOe)
        else $error("tdo driven after a tms-high edge");
    oe_rise_a: assert property (@(posedge tck)
        disable iff (!tapRstN) armed_q && $rose(tdoOe) |-> !$past(tms))
        else $error("tdo enabled without shift entry");
    oe_fall_a: assert property (@(posedge tck)
        disable iff (!tapRstN) armed_q && $fell(tdoOe) |-> $past(tms))
        else $error("tdo released while tms low");
    shift_hold_a: assert property (@(posedge tck)
        disable iff (!tapRstN) tdoOe && !tms |=> tdoOe)
        else $error("shift left while tms low");
    trst_quiet_a: assert property (@(posedge tck)
        disable iff (!tapRstN) $rose(tapRstN) |-> !tdoOe)
        else $error("tdo driven right after test reset");
    pad_reset_a: assert property (@(posedge core_clk)
        disable iff (!arst_n) $rose(arst_n) |->
        padOut == '0 && padOe == '0 && coreInputSubstitute == '0)
        else $error("pins not quiet at reset release");
    pad_follow_a: assert property (@(posedge core_clk)
        disable iff (!arst_n) $rose(arst_n) |-> ##2
        padOut == $past(coreOutputValue) &&
        padOe == ~$past(coreOutputEnableN))
        else $error("pins not following core after reset");
    core_in_a: assert property (@(posedge core_clk)
        disable iff (!arst_n) $rose(arst_n) |-> ##4
        coreInputSubstitute == $past(padIn, 3))
        else $error("core input not live after reset");
    cover property (@(posedge tck) $rose(tdoOe));
    cover property (@(posedge core_clk) padOe != '0);
    cover property (@(posedge core_clk) coreInputSubstitute != padIn);
endmodule

bind bsim_top bsim_top_chk #(.NUM_PINS(NUM_PINS)) chk (
    .core_clk(core_clk), .arst_n(arst_n), .tck(tck), .trstN(trstN),
    .tms(tms), .tdoOe(tdoOe), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .coreOutputValue(coreOutputValue),
    .coreOutputEnableN(coreOutputEnableN),
    .coreInputSubstitute(coreInputSubstitute)
);

// ---- verification/bsim_host.sv ----
// test port host model: drives tck, tms and tdi, reads tdo
`timescale 1ns/1ns
module bsim_host (
    // test port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdoOe
);
    logic tdoLast;
    logic tdoWire;
    // a released tdo shows the inverse of its last driven bit
    always_latch begin
        if (tdoOe) begin
            tdoLast <= tdo;
        end
    end
    assign tdoWire = tdoOe ? tdo : ~tdoLast;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one tck pulse; tdo read just before the rising edge
    task automatic pulse(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #6;
        o = tdoWire;
        tck = 1'b1;
        #6;
        tck = 1'b0;
    endtask
    task automatic move(input logic [7:0] pat, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            pulse(pat[i], 1'b0, o);
        end
    endtask
    // scan n bits lsb first from idle, back to idle via update
    task automatic scan(input logic isIr, input int n,
                        input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        move(8'h00, 4);
        move(isIr ? 8'h03 : 8'h01, isIr ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], dout[i]);
        end
        move(8'h01, 2);
        for (int i = 0; i < 60; i++) begin
            pulse(1'b0, 1'b0, o);
        end
    endtask
endmodule

// ---- verification/test_bsim_top.sv ----
// self-checking bench for the boundary-scan block
`timescale 1ns/1ns
module test_bsim_top;
    import bsim_pkg::*;
    localparam int NP = BSIM_PINS;
    localparam int CW = BSIM_CELL_W * BSIM_PINS;
    logic          core_clk;
    logic          arst_n;
    logic          trstN;
    logic          tck;
    logic          tms;
    logic          tdi;
    logic          tdo;
    logic          tdoOe;
    logic          cfgDone;
    logic [31:0]   userSig;
    logic [NP-1:0] padIn;
    logic [NP-1:0] padOut;
    logic [NP-1:0] padOe;
    logic [NP-1:0] extIn;
    logic [NP-1:0] coreOut;
    logic [NP-1:0] coreOeN;
    logic [NP-1:0] coreIn;
    logic [NP-1:0] keeperEn;
    logic [31:0]   d;
    logic [CW-1:0] pat;
    int            errTotal;
    int            checked;
    bsim_top DUT (
        .core_clk(core_clk), .arst_n(arst_n), .tck(tck), .trstN(trstN),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .coreOutputValue(coreOut),
        .coreOutputEnableN(coreOeN), .coreInputSubstitute(coreIn),
        .cfgDone(cfgDone), .userSignature(userSig), .keeperEn(keeperEn)
    );
    bsim_host host (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe)
    );
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // a driven pin reads back, a released one sees the outside level
    always @(posedge core_clk) padIn <= (padOe & padOut) | (~padOe & extIn);
    function automatic logic [CW-1:0] cells(input logic [NP-1:0] o,
        input logic [NP-1:0] e, input logic [NP-1:0] i);
        for (int k = 0; k < NP; k++) begin
            cells[3*k+:3] = {o[k], e[k], i[k]};
        end
    endfunction
    function automatic logic [NP-1:0] fld(input logic [CW-1:0] c, int f);
        for (int k = 0; k < NP; k++) begin
            fld[k] = c[3*k+f];
        end
    endfunction
    function automatic logic [NP-1:0] lvl(input logic [NP-1:0] o,
                                          input logic [NP-1:0] e);
        return (~e & o) | (e & extIn);
    endfunction
    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED %0t scan %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmpPins(input logic [NP-1:0] got, input logic [NP-1:0] exp);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED %0t pins %b expected %b", $time, got, exp);
        end
    endtask
    task automatic loadIr(input logic [BSIM_IR_W-1:0] code);
        host.scan(1'b1, BSIM_IR_W, {22'h0, code}, d);
    endtask
    task automatic testIdent();
        host.scan(1'b0, 32, 32'h0, d);
        cmpWord(d, BSIM_IDCODE_DEF);
        loadIr(BSIM_IR_BYPASS);
        cmpWord(d, {22'h0, BSIM_IR_CAPT});
        host.scan(1'b0, 8, 32'h0000_00A5, d);
        cmpWord(d, (32'h0000_00A5 << 1) & 32'h0000_00FF);
    endtask
    task automatic testUser();
        loadIr(BSIM_IR_USER);
        host.scan(1'b0, 32, 32'h0, d);
        cmpWord(d, BSIM_USERSIG_DEF);
        @(posedge core_clk);
        cfgDone <= 1'b1;
        userSig <= 32'h1357_9BDF;
        host.scan(1'b0, 32, 32'h0, d);
        cmpWord(d, 32'h1357_9BDF);
    endtask
    task automatic testSample();
        @(posedge core_clk);
        coreOeN <= 4'b0110;
        repeat (6) @(posedge core_clk);
        loadIr(BSIM_IR_SAMPLE);
        pat = 12'h9C6;
        host.scan(1'b0, 2 * CW, {8'h0, pat, 12'h5A3}, d);
        cmpWord(d, {8'h0, 12'h5A3, cells(coreOut, coreOeN,
                lvl(coreOut, coreOeN))});
        cmpPins(padOut, coreOut);
        cmpPins(padOe, ~coreOeN);
    endtask
    task automatic testExtest();
        loadIr(BSIM_IR_EXTEST);
        cmpPins(padOut, fld(pat, 2));
        cmpPins(padOe, ~fld(pat, 1));
        cmpPins(coreIn, fld(pat, 0));
        host.scan(1'b0, CW, {20'h0, 12'h3A5}, d);
        cmpWord(d, {20'h0, cells(coreOut, coreOeN,
                lvl(fld(pat, 2), fld(pat, 1)))});
        pat = 12'h3A5;
        cmpPins(padOut, fld(pat, 2));
        cmpPins(padOe, ~fld(pat, 1));
    endtask
    task automatic testClamp();
        @(posedge core_clk);
        keeperEn <= 4'b0101;
        loadIr(BSIM_IR_CLAMP);
        cmpPins(padOut, fld(pat, 2));
        cmpPins(padOe, ~fld(pat, 1) & ~keeperEn);
        cmpPins(coreIn, padIn);
        host.scan(1'b0, 4, 32'h0000_000D, d);
        cmpWord(d, (32'h0000_000D << 1) & 32'h0000_000F);
    endtask
    task automatic testReset();
        host.move(8'h1F, 5);
        repeat (6) host.move(8'hFF, 8);
        cmpPins(padOut, coreOut);
        cmpPins(padOe, ~coreOeN);
        host.scan(1'b0, 32, 32'h0, d);
        cmpWord(d, BSIM_IDCODE_DEF);
        cmpPins(padOut, coreOut);
        loadIr(BSIM_IR_BYPASS);
        @(posedge core_clk);
        trstN <= 1'b0;
        host.move(8'h03, 2);
        @(posedge core_clk);
        trstN <= 1'b1;
        host.scan(1'b0, 32, 32'h0, d);
        cmpWord(d, BSIM_IDCODE_DEF);
    endtask
    task automatic summarize();
        if (errTotal == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errTotal++;
        summarize();
    end
    initial begin
        {arst_n, trstN, cfgDone, userSig, keeperEn} = '0;
        trstN = 1'b1;
        {coreOut, coreOeN, extIn} = {4'hA, 4'hF, 4'h3};
        {errTotal, checked, pat} = '0;
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        testIdent();
        testUser();
        testSample();
        testExtest();
        testClamp();
        testReset();
        summarize();
    end
endmodule
